//--- src/sstep_cfg.svh
// Register map, field codes, reset values and timing counts for the selection step block.
`ifndef SSTEP_CFG_SVH
`define SSTEP_CFG_SVH
`define SSTEP_IDX_CMD 4'h3
`define SSTEP_IDX_STATUS 4'h4
`define SSTEP_IDX_TIMEOUT 4'h5
`define SSTEP_IDX_CAUSE 4'h5
`define SSTEP_IDX_STEP 4'h6
`define SSTEP_IDX_CLKF 4'h9
`define SSTEP_TIMEOUT_RST 8'h00
`define SSTEP_CLKF_RST 3'h0
`define SSTEP_CMD_LEN_RST 4'h6
`define SSTEP_CAUSE_DIS 8'h20
`define SSTEP_CAUSE_DONE 8'h18
`define SSTEP_STEP_SEL 3'h0
`define SSTEP_STEP_STOP 3'h1
`define SSTEP_STEP_MSG 3'h2
`define SSTEP_STEP_CMD 3'h3
`define SSTEP_STEP_END 3'h4
`define SSTEP_PRESCALE_BASE 8192
`define SSTEP_CLKF_ZERO_FACTOR 8
`define SSTEP_ATN3_BYTES 4'h3
`endif

//--- src/sstep_pkg.sv
// Types shared by the selection step block.
`default_nettype none
package sstep_pkg;
  typedef enum logic [2:0] {
    SSTEP_S_IDLE = 3'b000,
    SSTEP_S_SELECT = 3'b001,
    SSTEP_S_MSG_WAIT = 3'b010,
    SSTEP_S_MSG_ACK = 3'b011,
    SSTEP_S_CMD_WAIT = 3'b100,
    SSTEP_S_CMD_ACK = 3'b101
  } sstep_state_type;
  typedef enum logic [3:0] {
    SSTEP_OP_NOP = 4'h0,
    SSTEP_OP_SOFT_RESET = 4'h1,
    SSTEP_OP_SEL = 4'h2,
    SSTEP_OP_SEL_ATN = 4'h3,
    SSTEP_OP_SEL_ATN3 = 4'h4,
    SSTEP_OP_SEL_ATN_STOP = 4'h5
  } sstep_op_type;
  typedef struct packed {
    logic bsy;
    logic req;
    logic msg;
    logic cd;
    logic io;
  } sstep_bus_in_type;
  typedef struct packed {
    logic sel;
    logic atn;
    logic ack;
  } sstep_bus_out_type;
  localparam logic [2:0] SSTEP_PHASE_MSG_OUT = 3'b110;
  localparam logic [2:0] SSTEP_PHASE_COMMAND = 3'b010;
endpackage
`default_nettype wire

//--- src/sstep_timer.sv
// Selection timeout timer and select sequence step tracker with a Wishbone register port.
//
// Added by the designer: register access over Wishbone.
`timescale 1ns/1ps
`include "sstep_cfg.svh"
`default_nettype none
module sstep_timer #(
  parameter int PRESCALE_BASE = `SSTEP_PRESCALE_BASE
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire sstep_pkg::sstep_bus_in_type scsi_i,
  output sstep_pkg::sstep_bus_out_type scsi_o,
  input wire logic offset_at_max
);
  import sstep_pkg::*;

  if (PRESCALE_BASE < 1 || PRESCALE_BASE > `SSTEP_PRESCALE_BASE) begin : g_bad_prescale
    $error("PRESCALE_BASE out of range");
  end

  // Prescale period minus one for a given divisor factor; factor zero counts as eight.
  function automatic logic [16:0] prescale_limit(input logic [2:0] f);
    logic [19:0] prod;
    prod = 20'(PRESCALE_BASE) * ((f == 3'h0) ? 20'(`SSTEP_CLKF_ZERO_FACTOR) : 20'(f));
    return 17'(prod - 20'h00001);
  endfunction

  // Three-stage input synchroniser; a change counts once stages two and three agree.
  sstep_bus_in_type sync1_reg, sync2_reg, sync3_reg, bus_reg, bus_next;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      sync3_reg <= '0;
      bus_reg <= '0;
    end else begin
      sync1_reg <= scsi_i;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      bus_reg <= bus_next;
    end
  end
  assign bus_next = (sync2_reg == sync3_reg) ? sync3_reg : bus_reg;
  wire logic [2:0] phase = {bus_reg.msg, bus_reg.cd, bus_reg.io};

  // Wishbone decode.
  logic ack_reg;
  logic [31:0] dat_reg, dat_next;
  wire logic req = wb_cyc_i && wb_stb_i && !ack_reg;
  wire logic [3:0] idx = wb_adr_i[5:2];
  wire logic wr = req && wb_we_i && wb_sel_i[0];
  wire logic rd = req && !wb_we_i;
  wire logic wr_cmd = wr && idx == `SSTEP_IDX_CMD;
  wire logic wr_timeout = wr && idx == `SSTEP_IDX_TIMEOUT;
  wire logic wr_clkf = wr && idx == `SSTEP_IDX_CLKF;
  wire logic rd_cause = rd && idx == `SSTEP_IDX_CAUSE;
  wire logic [3:0] cmd_op = wb_dat_i[3:0];
  wire logic soft_rst = wr_cmd && cmd_op == SSTEP_OP_SOFT_RESET;

  sstep_state_type state_reg, state_next;
  sstep_op_type variant_reg, variant_next;
  sstep_bus_out_type out_reg, out_next;
  logic [7:0] timeout_reg, timeout_next;
  logic [2:0] clkf_reg, clkf_next;
  logic [3:0] len_reg, len_next;
  logic [2:0] step_reg, step_next;
  logic [7:0] cause_reg, cause_next;
  logic pend_reg, pend_next;
  logic [7:0] timer_reg, timer_next;
  logic [16:0] pre_reg, pre_next;
  logic [3:0] bytes_reg, bytes_next;

  wire logic sel_op = cmd_op inside {SSTEP_OP_SEL, SSTEP_OP_SEL_ATN, SSTEP_OP_SEL_ATN3, SSTEP_OP_SEL_ATN_STOP};
  wire logic start = wr_cmd && sel_op && state_reg == SSTEP_S_IDLE;
  wire logic tick = pre_reg == prescale_limit(clkf_reg);
  wire logic expire = tick && timer_reg <= 8'h01;
  wire logic [3:0] msg_count = (variant_reg == SSTEP_OP_SEL_ATN3) ? `SSTEP_ATN3_BYTES : 4'h1;
  wire logic last_msg = bytes_reg == msg_count;
  wire logic is_stop = variant_reg == SSTEP_OP_SEL_ATN_STOP;

  assign timeout_next = wr_timeout ? wb_dat_i[7:0] : timeout_reg;
  assign clkf_next = wr_clkf ? wb_dat_i[2:0] : clkf_reg;
  assign len_next = start ? wb_dat_i[7:4] : len_reg;

  always_comb begin
    state_next = state_reg;
    variant_next = variant_reg;
    out_next = out_reg;
    step_next = step_reg;
    cause_next = cause_reg;
    pend_next = pend_reg;
    timer_next = timer_reg;
    pre_next = pre_reg;
    bytes_next = bytes_reg;
    if (rd_cause && pend_reg) begin
      step_next = 3'h0;
      cause_next = 8'h00;
      pend_next = 1'b0;
    end
    unique case (state_reg)
      SSTEP_S_IDLE: begin
        if (start) begin
          variant_next = sstep_op_type'(cmd_op);
          out_next.sel = 1'b1;
          out_next.atn = cmd_op != SSTEP_OP_SEL;
          out_next.ack = 1'b0;
          timer_next = timeout_reg;
          pre_next = 17'h00000;
          step_next = `SSTEP_STEP_SEL;
          bytes_next = 4'h0;
          state_next = SSTEP_S_SELECT;
        end
      end
      SSTEP_S_SELECT: begin
        pre_next = tick ? 17'h00000 : pre_reg + 17'h00001;
        if (tick && timer_reg != 8'h00) begin
          timer_next = timer_reg - 8'h01;
        end
        if (bus_reg.bsy) begin
          out_next.sel = 1'b0;
          if (variant_reg == SSTEP_OP_SEL) begin
            step_next = `SSTEP_STEP_MSG;
            state_next = SSTEP_S_CMD_WAIT;
          end else begin
            state_next = SSTEP_S_MSG_WAIT;
          end
        end else if (expire) begin
          out_next = '0;
          step_next = `SSTEP_STEP_SEL;
          cause_next = cause_next | `SSTEP_CAUSE_DIS;
          pend_next = 1'b1;
          state_next = SSTEP_S_IDLE;
        end
      end
      SSTEP_S_MSG_WAIT: begin
        if (!bus_reg.bsy) begin
          out_next = '0;
          cause_next = cause_next | `SSTEP_CAUSE_DIS;
          pend_next = 1'b1;
          state_next = SSTEP_S_IDLE;
        end else if (bus_reg.req) begin
          if (phase == SSTEP_PHASE_MSG_OUT) begin
            out_next.ack = 1'b1;
            bytes_next = bytes_reg + 4'h1;
            state_next = SSTEP_S_MSG_ACK;
          end else begin
            cause_next = cause_next | `SSTEP_CAUSE_DONE;
            pend_next = 1'b1;
            state_next = SSTEP_S_IDLE;
          end
        end
      end
      SSTEP_S_MSG_ACK: begin
        if (last_msg && !is_stop) begin
          out_next.atn = 1'b0;
        end
        if (!bus_reg.req) begin
          out_next.ack = 1'b0;
          step_next = is_stop ? `SSTEP_STEP_STOP : `SSTEP_STEP_MSG;
          if (last_msg && is_stop) begin
            cause_next = cause_next | `SSTEP_CAUSE_DONE;
            pend_next = 1'b1;
            state_next = SSTEP_S_IDLE;
          end else if (last_msg) begin
            bytes_next = 4'h0;
            state_next = SSTEP_S_CMD_WAIT;
          end else begin
            state_next = SSTEP_S_MSG_WAIT;
          end
        end
      end
      SSTEP_S_CMD_WAIT: begin
        if (!bus_reg.bsy) begin
          out_next = '0;
          cause_next = cause_next | `SSTEP_CAUSE_DIS;
          pend_next = 1'b1;
          state_next = SSTEP_S_IDLE;
        end else if (bus_reg.req) begin
          if (phase == SSTEP_PHASE_COMMAND) begin
            step_next = `SSTEP_STEP_CMD;
            out_next.ack = 1'b1;
            bytes_next = bytes_reg + 4'h1;
            state_next = SSTEP_S_CMD_ACK;
          end else begin
            cause_next = cause_next | `SSTEP_CAUSE_DONE;
            pend_next = 1'b1;
            state_next = SSTEP_S_IDLE;
          end
        end
      end
      SSTEP_S_CMD_ACK: begin
        if (!bus_reg.req) begin
          out_next.ack = 1'b0;
          if (bytes_reg == len_reg) begin
            step_next = `SSTEP_STEP_END;
            cause_next = cause_next | `SSTEP_CAUSE_DONE;
            pend_next = 1'b1;
            state_next = SSTEP_S_IDLE;
          end else begin
            state_next = SSTEP_S_CMD_WAIT;
          end
        end
      end
      default: begin
        out_next = '0;
        state_next = SSTEP_S_IDLE;
      end
    endcase
    if (soft_rst) begin
      out_next = '0;
      step_next = 3'h0;
      cause_next = 8'h00;
      pend_next = 1'b0;
      state_next = SSTEP_S_IDLE;
    end
  end

  // Read data; the step register reports the offset flag low-active.
  wire logic [7:0] step_view = {4'h0, !offset_at_max, step_reg};
  wire logic [7:0] status_view = {pend_reg, state_reg != SSTEP_S_IDLE, 3'h0, phase};
  always_comb begin
    dat_next = 32'h00000000;
    if (rd) begin
      unique case (idx)
        `SSTEP_IDX_CAUSE: dat_next = {24'h000000, cause_reg};
        `SSTEP_IDX_STEP: dat_next = {24'h000000, step_view};
        `SSTEP_IDX_STATUS: dat_next = {24'h000000, status_view};
        default: dat_next = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timeout_reg <= `SSTEP_TIMEOUT_RST;
      clkf_reg <= `SSTEP_CLKF_RST;
      len_reg <= `SSTEP_CMD_LEN_RST;
      step_reg <= 3'h0;
      cause_reg <= 8'h00;
      pend_reg <= 1'b0;
      timer_reg <= 8'h00;
      pre_reg <= 17'h00000;
      bytes_reg <= 4'h0;
      state_reg <= SSTEP_S_IDLE;
      variant_reg <= SSTEP_OP_NOP;
      out_reg <= '0;
      ack_reg <= 1'b0;
      dat_reg <= 32'h00000000;
    end else begin
      timeout_reg <= timeout_next;
      clkf_reg <= clkf_next;
      len_reg <= len_next;
      step_reg <= step_next;
      cause_reg <= cause_next;
      pend_reg <= pend_next;
      timer_reg <= timer_next;
      pre_reg <= pre_next;
      bytes_reg <= bytes_next;
      state_reg <= state_next;
      variant_reg <= variant_next;
      out_reg <= out_next;
      ack_reg <= req;
      dat_reg <= dat_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;
  assign scsi_o = out_reg;

  // Checks.
  sequence s_expire;
    state_reg == SSTEP_S_SELECT && !bus_reg.bsy && expire && !soft_rst;
  endsequence
  sequence s_cmd_end;
    state_reg == SSTEP_S_CMD_ACK && !bus_reg.req && bytes_reg == len_reg && !soft_rst;
  endsequence
  sequence s_reported(logic [2:0] code);
    state_reg == SSTEP_S_IDLE && step_reg == code && (cause_reg & `SSTEP_CAUSE_DONE) == `SSTEP_CAUSE_DONE;
  endsequence

  sel_timeout_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_expire |=> step_reg == 3'h0 && cause_reg[5] && !scsi_o.sel && !scsi_o.atn && pend_reg)
    else $error("selection timeout not reported");
  seq_done_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_cmd_end |=> s_reported(`SSTEP_STEP_END))
    else $error("completed sequence not reported");
  cmd_halt_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == SSTEP_S_CMD_WAIT && step_reg == 3'h3 && bus_reg.bsy && bus_reg.req
      && phase != SSTEP_PHASE_COMMAND && !soft_rst && !rd_cause |=> s_reported(3'h3))
    else $error("premature phase change not halted at step 3");
  no_cmd_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == SSTEP_S_CMD_WAIT && step_reg == 3'h2 && bus_reg.bsy && bus_reg.req
      && phase != SSTEP_PHASE_COMMAND && !soft_rst && !rd_cause |=> s_reported(3'h2))
    else $error("missing command phase not halted at step 2");
  atn_kept_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == SSTEP_S_MSG_WAIT && bytes_reg == 4'h0 && bus_reg.bsy && bus_reg.req
      && phase != SSTEP_PHASE_MSG_OUT && !soft_rst && !rd_cause |=> s_reported(3'h0) ##0 scsi_o.atn)
    else $error("attention dropped on missing message out");
  stop_halt_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == SSTEP_S_MSG_ACK && is_stop && !bus_reg.req && !soft_rst
      |=> s_reported(3'h1) ##0 scsi_o.atn)
    else $error("stop variant did not halt at step 1");
  atn_release_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == SSTEP_S_MSG_ACK && last_msg && !is_stop && !soft_rst |=> !scsi_o.atn)
    else $error("attention not released after last message byte");
  read_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    rd_cause && pend_reg && state_reg == SSTEP_S_IDLE && !start |=> step_reg == 3'h0 && !pend_reg)
    else $error("cause read did not clear step");
  step_view_a: assert property (@(posedge clk) disable iff (!rst_n)
    rd && idx == `SSTEP_IDX_STEP |=> wb_ack_o && wb_dat_o[7:4] == 4'h0 && wb_dat_o[3] == !$past(offset_at_max))
    else $error("step register view wrong");
  timer_load_a: assert property (@(posedge clk) disable iff (!rst_n)
    start |=> timer_reg == $past(timeout_reg) && state_reg == SSTEP_S_SELECT && scsi_o.sel)
    else $error("timer not loaded at selection start");
  sequence s_lost;
    (state_reg == SSTEP_S_MSG_WAIT || state_reg == SSTEP_S_CMD_WAIT) && !bus_reg.bsy && !soft_rst;
  endsequence
  disc_seen_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_lost |=> cause_reg[5] && pend_reg && scsi_o == '0 && state_reg == SSTEP_S_IDLE)
    else $error("target disconnect not reported");
  soft_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    soft_rst |=> step_reg == 3'h0 && !pend_reg && state_reg == SSTEP_S_IDLE && scsi_o == '0)
    else $error("soft reset did not clear step");
  hard_clear_a: assert property (@(posedge clk)
    !rst_n |=> timeout_reg == `SSTEP_TIMEOUT_RST && step_reg == 3'h0)
    else $error("hard reset did not clear timeout");
  cmd_step_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == SSTEP_S_CMD_WAIT && bus_reg.bsy && bus_reg.req && phase == SSTEP_PHASE_COMMAND && !soft_rst
      |=> step_reg == `SSTEP_STEP_CMD && scsi_o.ack)
    else $error("command byte step not recorded");
  timer_dec_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == SSTEP_S_SELECT && tick && timer_reg != 8'h00 |=> timer_reg == $past(timer_reg) - 8'h01)
    else $error("timer did not count down on prescale tick");
  cmd_atn_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == SSTEP_S_CMD_WAIT || state_reg == SSTEP_S_CMD_ACK |-> !scsi_o.atn)
    else $error("attention still driven in command phase");
  atn3_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == SSTEP_S_MSG_WAIT && variant_reg == SSTEP_OP_SEL_ATN3 |-> scsi_o.atn)
    else $error("attention released before third message byte");
endmodule
`default_nettype wire

//--- tb/sstep_target_model.sv
// Behavioural target that answers selection and runs message-out and command bytes.
`timescale 1ns/1ps
`default_nettype none
module sstep_target_model (
  input wire logic clk,
  input wire logic go,
  input wire logic [3:0] dly,
  input wire logic [3:0] n_msg,
  input wire logic [3:0] n_cmd,
  input wire logic [3:0] end_ph,
  input wire sstep_pkg::sstep_bus_out_type bus_o,
  output sstep_pkg::sstep_bus_in_type bus_i
);
  import sstep_pkg::*;
  logic bsy = 1'b0;
  logic req = 1'b0;
  logic [2:0] ph = 3'h0;
  // Released phase lines read deasserted, as the bus terminators pull them there.
  assign bus_i = {bsy, req, bsy ? ph : 3'h0};
  task automatic xfer(input logic [2:0] p);
    ph <= p;
    repeat (2) @(posedge clk);
    req <= 1'b1;
    do @(posedge clk); while (bus_o.ack !== 1'b1);
    req <= 1'b0;
    do @(posedge clk); while (bus_o.ack !== 1'b0);
  endtask
  always begin
    @(posedge clk);
    if (go && bus_o.sel && !bsy) begin
      repeat (dly) @(posedge clk);
      bsy <= 1'b1;
      repeat (n_msg) xfer(SSTEP_PHASE_MSG_OUT);
      repeat (n_cmd) xfer(SSTEP_PHASE_COMMAND);
      if (end_ph == 4'h1) begin
        repeat (8) @(posedge clk);
        bsy <= 1'b0;
      end
      if (end_ph[3]) begin
        ph <= end_ph[2:0];
        repeat (2) @(posedge clk);
        req <= 1'b1;
      end
      while (go) @(posedge clk);
      bsy <= 1'b0;
      req <= 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- tb/sstep_timer_tb.sv
// Register-level testbench for the selection timeout and step tracker.
`timescale 1ns/1ps
`default_nettype none
module sstep_timer_tb;
  import sstep_pkg::*;
  typedef struct packed {
    logic [7:0] cmd;
    logic go;
    logic [3:0] dly, nm, nc, endp;
    logic [2:0] step;
    logic [7:0] cause;
    logic atn;
  } sstep_row_type;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
  logic [5:0] wb_adr = 6'h00;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_dat = 32'h0, wb_q, q;
  logic wb_ack;
  logic ofs = 1'b0;
  logic go = 1'b0;
  logic [3:0] dly = 4'h0, nm = 4'h0, nc = 4'h0, endp = 4'h0;
  sstep_bus_in_type scsi_i;
  sstep_bus_out_type scsi_o;
  int fail_count = 0;
  int checked = 0;
  int cycles = 0;
  sstep_row_type rows [11] = '{
    '{8'h12, 1'b0, 4'h0, 4'h0, 4'h0, 4'h0, 3'h0, 8'h20, 1'b0},
    '{8'h22, 1'b1, 4'h0, 4'h0, 4'h2, 4'h0, 3'h4, 8'h18, 1'b0},
    '{8'h12, 1'b1, 4'h6, 4'h0, 4'h0, 4'hb, 3'h2, 8'h18, 1'b0},
    '{8'h23, 1'b1, 4'h0, 4'h1, 4'h1, 4'hb, 3'h3, 8'h18, 1'b0},
    '{8'h13, 1'b1, 4'h0, 4'h1, 4'h0, 4'hb, 3'h2, 8'h18, 1'b0},
    '{8'h13, 1'b1, 4'h0, 4'h1, 4'h1, 4'h0, 3'h4, 8'h18, 1'b0},
    '{8'h13, 1'b1, 4'h0, 4'h0, 4'h0, 4'ha, 3'h0, 8'h18, 1'b1},
    '{8'h14, 1'b1, 4'h6, 4'h3, 4'h1, 4'h0, 3'h4, 8'h18, 1'b0},
    '{8'h14, 1'b1, 4'h0, 4'h2, 4'h0, 4'hb, 3'h2, 8'h18, 1'b1},
    '{8'h13, 1'b1, 4'h0, 4'h0, 4'h0, 4'h1, 3'h0, 8'h20, 1'b0},
    '{8'h15, 1'b1, 4'h0, 4'h1, 4'h0, 4'h0, 3'h1, 8'h18, 1'b1}
  };
  sstep_timer #(.PRESCALE_BASE(4)) u_dut (
    .clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_q), .wb_ack_o(wb_ack),
    .scsi_i(scsi_i), .scsi_o(scsi_o), .offset_at_max(ofs)
  );
  sstep_target_model u_target (
    .clk(clk), .go(go), .dly(dly), .n_msg(nm), .n_cmd(nc), .end_ph(endp), .bus_o(scsi_o), .bus_i(scsi_i)
  );
  always #10 clk = ~clk;
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count = fail_count + 1;
      give_verdict();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked = checked + 1;
    if (seen !== exp) begin
      fail_count = fail_count + 1;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic we, input logic [5:0] adr, input logic [7:0] d, output logic [31:0] r);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_sel <= 4'hf;
    wb_dat <= {24'h0, d};
    do @(posedge clk); while (wb_ack !== 1'b1);
    r = wb_q;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wait_pending();
    for (int i = 0; i < 100; i++) begin
      bus(1'b0, 6'h10, 8'h00, q);
      if (q[7] === 1'b1) break;
    end
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    bus(1'b0, 6'h18, 8'h00, q);
    check(q, 32'h08);
    bus(1'b0, 6'h3c, 8'h00, q);
    check(q, 32'h0);
    bus(1'b1, 6'h0c, 8'h02, q);
    repeat (20) @(posedge clk);
    check({31'h0, scsi_o.sel}, 32'h1);
    repeat (20) @(posedge clk);
    check({31'h0, scsi_o.sel}, 32'h0);
    wait_pending();
    bus(1'b0, 6'h14, 8'h00, q);
    check(q, 32'h20);
    bus(1'b1, 6'h24, 8'h01, q);
    bus(1'b1, 6'h14, 8'h05, q);
    ofs <= 1'b1;
    foreach (rows[i]) begin
      go <= rows[i].go;
      dly <= rows[i].dly;
      nm <= rows[i].nm;
      nc <= rows[i].nc;
      endp <= rows[i].endp;
      bus(1'b1, 6'h0c, rows[i].cmd, q);
      wait_pending();
      bus(1'b0, 6'h18, 8'h00, q);
      check(q, {29'h0, rows[i].step});
      check({31'h0, scsi_o.atn}, {31'h0, rows[i].atn});
      bus(1'b0, 6'h14, 8'h00, q);
      check(q, {24'h0, rows[i].cause});
      bus(1'b0, 6'h18, 8'h00, q);
      check(q, 32'h0);
      go <= 1'b0;
      repeat (4) @(posedge clk);
      bus(1'b1, 6'h0c, 8'h01, q);
      check({31'h0, scsi_o.atn}, 32'h0);
    end
    give_verdict();
  end
endmodule
`default_nettype wire
